// File: core/dism_cfg.svh
`ifndef DISM_CFG_SVH
`define DISM_CFG_SVH

// ***********************************************
// register map
// ***********************************************
`define DISM_ADDR_W 8
`define DISM_OFS_CTRL 8'h00
`define DISM_OFS_STATUS 8'h04
`define DISM_OFS_RELAY 8'h08

// ***********************************************
// field positions and reset values
// ***********************************************
`define DISM_CTRL_SUPEN 0
`define DISM_CTRL_SEFTGL 1
`define DISM_CTRL_RESET 1'h0
`define DISM_STAT_SEF 5
`define DISM_STAT_CNTOFF 6
`define DISM_STAT_PWR 7

// ***********************************************
// input types and relay types
// ***********************************************
`define DISM_MOMENTARY_MASK 5'h1B
`define DISM_LATCH_MASK 12'hFC0

// ***********************************************
// timing
// ***********************************************
`define DISM_CLOCK_MHZ 125
`define DISM_TICK_NS 1000
`define DISM_TICK_CYCLES ((`DISM_TICK_NS * `DISM_CLOCK_MHZ) / 1000)
`define DISM_DEBOUNCE_US 1000
`define DISM_DEBOUNCE_TICKS \
	((`DISM_DEBOUNCE_US * 1000) / `DISM_TICK_NS)

`endif

// File: core/dism_debounce.sv
`default_nettype none

module dism_debounce #(
	parameter int W = 5,
	parameter int TICKS = 1000
) (
	input wire logic clock, // system clock
	input wire logic resetn, // async reset, low
	input wire logic tick, // debounce rate enable
	input wire logic [W-1:0] rawIn, // whetted inputs
	output logic [W-1:0] level, // filtered level
	output logic [W-1:0] rise // one-cycle rising edge
);

	localparam int CW = $clog2(TICKS + 1);

	logic [W-1:0] sync1_q;
	logic [W-1:0] sync2_q;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			sync1_q <= '0;
			sync2_q <= '0;
		end
		else
		begin
			sync1_q <= rawIn;
			sync2_q <= sync1_q;
		end
	end

	// ***********************************************
	// per-input stability filter
	// ***********************************************
	genvar i;
	generate
		for (i = 0; i < W; i++)
		begin : g_bit
			logic [CW-1:0] cnt_q;
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
				begin
					cnt_q <= '0;
					level[i] <= 1'b0;
					rise[i] <= 1'b0;
				end
				else
				begin
					rise[i] <= 1'b0;
					if (sync2_q[i] == level[i])
						cnt_q <= '0;
					else if (tick)
					begin
						if (cnt_q == CW'(TICKS - 1))
						begin
							cnt_q <= '0;
							level[i] <= sync2_q[i];
							rise[i] <= sync2_q[i];
						end
						else
							cnt_q <= cnt_q + CW'(1);
					end
				end
			end
		end
	endgenerate

endmodule

`default_nettype wire

// File: core/dism_pkg.sv
`default_nettype none

package dism_pkg;

	// ***********************************************
	// indicator states from the control core
	// ***********************************************
	typedef struct packed {
		logic sefTarget;
		logic earthFaultTarget;
		logic target56;
		logic target34;
		logic target12;
		logic recloserMalfunction;
		logic fastTripsDisabled;
		logic reversePower;
		logic checkBattery;
		logic controlLockout;
	} dism_ind_s;

	// ***********************************************
	// key actions towards the control core
	// ***********************************************
	typedef struct packed {
		logic counterOff;
		logic batteryTestKey;
		logic resetTargetsKey;
		logic fastTripsKey;
	} dism_act_s;

	typedef logic [11:0] dism_relay_t;

endpackage

`default_nettype wire

// File: core/dism_relay_bank.sv
`default_nettype none
`include "dism_cfg.svh"

module dism_relay_bank #(
	parameter logic [11:0] LATCH_MASK = `DISM_LATCH_MASK
) (
	input wire logic clock, // system clock
	input wire logic resetn, // async reset, low
	input wire logic powerOk, // control power present
	input wire dism_pkg::dism_relay_t demand, // wanted coil states
	output dism_pkg::dism_relay_t coil // relay drive
);

	genvar i;
	generate
		for (i = 0; i < 12; i++)
		begin : g_relay
			always_ff @(posedge clock or negedge resetn)
			begin
				if (!resetn)
					coil[i] <= 1'b0;
				else if (powerOk)
					coil[i] <= demand[i];
				else if (!LATCH_MASK[i])
					coil[i] <= 1'b0;
			end
		end
	endgenerate

	// ***********************************************
	// checks
	// ***********************************************
	chk_power_loss_hold: assert property (
		@(posedge clock) disable iff (!resetn)
		!powerOk |=> coil == ($past(coil) & LATCH_MASK))
		else $error("relay state wrong after power loss");

	chk_relay_split: assert property (
		@(posedge clock) disable iff (!resetn)
		!powerOk [*2] |-> (coil & ~LATCH_MASK) == '0)
		else $error("non-latched relay held without power");

	cov_power_loss: cover property (
		@(posedge clock) disable iff (!resetn)
		powerOk ##1 !powerOk [*3] ##1 powerOk);

endmodule

`default_nettype wire

// File: core/dism_top.sv
// What this block does
// - each input fixed momentary or maintained
// - input 1 pulse presses fast-trips key
// - input 2 pulse presses reset-targets key
// - input 3 held stops operation counting
// - input 4 pulse starts battery test
// - input 5 pulse toggles earth-fault blocking
// - twelve relays, six latching, six not
// - outputs 1-4,6 mirror their indicators
// - output 5 when supervisory enabled and no counter-off request
// - outputs 7-9 follow phase fault targets
// - outputs 10-11 follow earth-fault targets
// - output 12 shows earth-fault blocked
`default_nettype none
`include "dism_cfg.svh"

module dism_top #(
	parameter logic [4:0] MOMENTARY_MASK = `DISM_MOMENTARY_MASK,
	parameter int TICK_CYCLES = `DISM_TICK_CYCLES,
	parameter int DEBOUNCE_TICKS = `DISM_DEBOUNCE_TICKS
) (
	input wire logic clock, // 125 MHz clock
	input wire logic resetn, // async reset, low
	input wire logic [`DISM_ADDR_W-1:0] regAddr, // register byte address
	input wire logic [31:0] regWdata, // write data
	input wire logic regWrite, // write strobe
	input wire logic regRead, // read strobe
	output logic [31:0] regRdata, // read data, next cycle
	input wire logic [4:0] whetIn, // whetted discrete inputs
	input wire dism_pkg::dism_ind_s indicators, // panel indicators
	input wire logic [2:0] commCounterOff, // counter-off per port
	input wire logic controlPowerOk, // control power present
	output dism_pkg::dism_act_s actions, // key pulses, counter off
	output dism_pkg::dism_relay_t relayOut // relay coils
);

	// ***********************************************
	// debounce rate divider
	// ***********************************************
	localparam int DW = $clog2(TICK_CYCLES + 1);

	logic [DW-1:0] div_q;
	logic tick_q;

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
		begin
			div_q <= '0;
			tick_q <= 1'b0;
		end
		else if (div_q == DW'(TICK_CYCLES - 1))
		begin
			div_q <= '0;
			tick_q <= 1'b1;
		end
		else
		begin
			div_q <= div_q + DW'(1);
			tick_q <= 1'b0;
		end
	end

	// ***********************************************
	// input filtering
	// ***********************************************
	logic [4:0] inLevel;
	logic [4:0] inRise;
	logic [4:0] momPulse;
	logic [4:0] maintLevel;

	dism_debounce #(
		.W(5),
		.TICKS(DEBOUNCE_TICKS)
	) u_debounce (
		.clock(clock),
		.resetn(resetn),
		.tick(tick_q),
		.rawIn(whetIn),
		.level(inLevel),
		.rise(inRise)
	);

	assign momPulse = inRise & MOMENTARY_MASK;
	assign maintLevel = inLevel & ~MOMENTARY_MASK;

	// ***********************************************
	// control register
	// ***********************************************
	logic supEn_q;
	logic swSefToggle;
	logic ctrlHit;

	assign ctrlHit = regWrite && (regAddr == `DISM_OFS_CTRL);
	assign swSefToggle = ctrlHit && regWdata[`DISM_CTRL_SEFTGL];

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			supEn_q <= `DISM_CTRL_RESET;
		else if (ctrlHit)
			supEn_q <= regWdata[`DISM_CTRL_SUPEN];
	end

	// ***********************************************
	// supervisory key actions
	// ***********************************************
	dism_pkg::dism_act_s act_d;

	always_comb
	begin
		act_d.fastTripsKey = supEn_q && momPulse[0];
		act_d.resetTargetsKey = supEn_q && momPulse[1];
		act_d.batteryTestKey = supEn_q && momPulse[3];
		act_d.counterOff = supEn_q && maintLevel[2];
	end

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			actions <= '0;
		else
			actions <= act_d;
	end

	// ***********************************************
	// sensitive earth-fault blocking state
	// ***********************************************
	logic sefBlocked_q;
	logic supSefToggle;

	assign supSefToggle = supEn_q && momPulse[4];

	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			sefBlocked_q <= 1'b0;
		else if (supSefToggle || swSefToggle)
			sefBlocked_q <= !sefBlocked_q;
	end

	// ***********************************************
	// relay demand
	// ***********************************************
	dism_pkg::dism_relay_t demand;

	always_comb
	begin
		demand[0] = indicators.controlLockout;
		demand[1] = indicators.checkBattery;
		demand[2] = indicators.reversePower;
		demand[3] = indicators.fastTripsDisabled;
		demand[4] = supEn_q && (commCounterOff == 3'h0);
		demand[5] = indicators.recloserMalfunction;
		demand[6] = indicators.target12;
		demand[7] = indicators.target34;
		demand[8] = indicators.target56;
		demand[9] = indicators.earthFaultTarget;
		demand[10] = indicators.sefTarget;
		demand[11] = sefBlocked_q;
	end

	dism_relay_bank #(
		.LATCH_MASK(`DISM_LATCH_MASK)
	) u_relays (
		.clock(clock),
		.resetn(resetn),
		.powerOk(controlPowerOk),
		.demand(demand),
		.coil(relayOut)
	);

	// ***********************************************
	// register read
	// ***********************************************
	always_ff @(posedge clock or negedge resetn)
	begin
		if (!resetn)
			regRdata <= 32'h0;
		else if (!regRead)
			regRdata <= 32'h0;
		else if (regAddr == `DISM_OFS_CTRL)
			regRdata <= {31'h0, supEn_q};
		else if (regAddr == `DISM_OFS_STATUS)
			regRdata <= {24'h0, controlPowerOk, actions.counterOff,
				sefBlocked_q, inLevel};
		else if (regAddr == `DISM_OFS_RELAY)
			regRdata <= {20'h0, relayOut};
		else
			regRdata <= 32'h0;
	end

	// ***********************************************
	// checks
	// ***********************************************
	chk_fast_key_issue: assert property (
		@(posedge clock) disable iff (!resetn)
		inRise[0] && supEn_q |=> actions.fastTripsKey)
		else $error("fast trips key not issued");

	chk_reset_key_gate: assert property (
		@(posedge clock) disable iff (!resetn)
		actions.resetTargetsKey |-> $past(inRise[1] && supEn_q))
		else $error("reset targets key without enabled pulse");

	chk_counter_off_level: assert property (
		@(posedge clock) disable iff (!resetn)
		inLevel[2] && supEn_q ##1 inLevel[2] && supEn_q
			|-> actions.counterOff)
		else $error("counter not held off");

	chk_battery_key_gate: assert property (
		@(posedge clock) disable iff (!resetn)
		!supEn_q |=> !actions.batteryTestKey)
		else $error("battery test issued while disabled");

	chk_sef_toggle: assert property (
		@(posedge clock) disable iff (!resetn)
		inRise[4] && supEn_q && !swSefToggle
			|=> sefBlocked_q != $past(sefBlocked_q))
		else $error("earth-fault blocking did not toggle");

	chk_single_action: assert property (
		@(posedge clock) disable iff (!resetn)
		actions.fastTripsKey |=> !actions.fastTripsKey)
		else $error("key pulse longer than one cycle");

	chk_lockout_mirror: assert property (
		@(posedge clock) disable iff (!resetn)
		controlPowerOk |=> relayOut[0] == $past(indicators.controlLockout))
		else $error("lockout relay not mirroring");

	chk_counter_relay: assert property (
		@(posedge clock) disable iff (!resetn)
		controlPowerOk && (commCounterOff != 3'h0) |=> !relayOut[4])
		else $error("counter relay on with counter-off request");

	chk_target_relays: assert property (
		@(posedge clock) disable iff (!resetn)
		controlPowerOk |=> relayOut[8:6] == $past({indicators.target56,
			indicators.target34, indicators.target12}))
		else $error("phase target relays wrong");

	chk_earth_targets: assert property (
		@(posedge clock) disable iff (!resetn)
		controlPowerOk |=> relayOut[10:9] == $past({indicators.sefTarget,
			indicators.earthFaultTarget}))
		else $error("earth-fault target relays wrong");

	chk_sef_relay: assert property (
		@(posedge clock) disable iff (!resetn)
		controlPowerOk |=> relayOut[11] == $past(sefBlocked_q))
		else $error("blocked relay not following state");

	chk_counter_off_gate: assert property (
		@(posedge clock) disable iff (!resetn)
		!supEn_q |=> !actions.counterOff)
		else $error("counter held off while disabled");

	chk_fast_key_gate: assert property (
		@(posedge clock) disable iff (!resetn)
		!supEn_q |=> !actions.fastTripsKey)
		else $error("fast trips key issued while disabled");

	chk_sef_hold: assert property (
		@(posedge clock) disable iff (!resetn)
		!(inRise[4] && supEn_q) && !swSefToggle
			|=> $stable(sefBlocked_q))
		else $error("earth-fault blocking changed unprompted");

	chk_input_type: assert property (
		@(posedge clock) disable iff (!resetn)
		actions.counterOff |-> $past(inLevel[2]))
		else $error("counter off without held input level");

	chk_other_mirrors: assert property (
		@(posedge clock) disable iff (!resetn)
		controlPowerOk |=> {relayOut[5], relayOut[3:1]} == $past({
			indicators.recloserMalfunction, indicators.fastTripsDisabled,
			indicators.reversePower, indicators.checkBattery}))
		else $error("indicator relays not mirroring");

	cov_fast_key: cover property (
		@(posedge clock) disable iff (!resetn)
		actions.fastTripsKey);

	cov_sef_toggle: cover property (
		@(posedge clock) disable iff (!resetn)
		!sefBlocked_q ##1 sefBlocked_q);

	cov_ignored_pulse: cover property (
		@(posedge clock) disable iff (!resetn)
		inRise[1] && !supEn_q);

endmodule

`default_nettype wire

// File: testbench/dism_scada_model.sv
`default_nettype none

module dism_scada_model (
	input wire logic clock, // system clock
	input wire logic [4:0] fire, // one-cycle pulse request
	input wire logic [4:0] hold, // maintained request
	output logic [4:0] whet // whetted lines
);
	timeunit 1ns;
	timeprecision 1ps;
	int left [5] = '{0, 0, 0, 0, 0};

	always @(posedge clock)
		for (int i = 0; i < 5; i++)
			left[i] <= fire[i] ? 20 : (left[i] > 0 ? left[i] - 1 : 0);

	// released contacts drop to no whetting
	always_comb
		for (int i = 0; i < 5; i++)
			whet[i] = hold[i] | (left[i] > 0);
endmodule

`default_nettype wire

// File: testbench/dism_top_tb.sv
`default_nettype none

module dism_top_tb;
	timeunit 1ns;
	timeprecision 1ps;
	logic clock = 1'b0, resetn = 1'b0, regWrite = 1'b0, regRead = 1'b0;
	logic controlPowerOk = 1'b1, supEn = 1'b0, blk = 1'b0;
	logic [7:0] regAddr = 8'h00;
	logic [31:0] regWdata = 32'h0, regRdata, rd;
	logic [4:0] fire = 5'h00, hold = 5'h00, whetIn;
	logic [2:0] commCounterOff = 3'h0;
	dism_pkg::dism_ind_s indicators = 10'h000;
	dism_pkg::dism_act_s actions;
	dism_pkg::dism_relay_t relayOut;
	int err_count = 0, n_compared = 0;
	int hits [3] = '{0, 0, 0};

	dism_top #(.TICK_CYCLES(2), .DEBOUNCE_TICKS(3)) dism_top_i (
		.clock(clock), .resetn(resetn), .regAddr(regAddr),
		.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead),
		.regRdata(regRdata), .whetIn(whetIn), .indicators(indicators),
		.commCounterOff(commCounterOff), .controlPowerOk(controlPowerOk),
		.actions(actions), .relayOut(relayOut));

	dism_scada_model dism_scada_model_i (
		.clock(clock), .fire(fire), .hold(hold), .whet(whetIn));

	initial
		forever #4 clock = ~clock;

	always @(posedge clock)
	begin
		if (actions.fastTripsKey === 1'b1) hits[0]++;
		if (actions.resetTargetsKey === 1'b1) hits[1]++;
		if (actions.batteryTestKey === 1'b1) hits[2]++;
	end

	// ************
	// shared tasks
	// ************
	task automatic test_done();
		if (err_count == 0 && n_compared > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask

	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			err_count++;
			$display("CHECK FAILED t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask

	task automatic regWr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		regAddr <= a;
		regWdata <= d;
		regWrite <= 1'b1;
		@(posedge clock);
		regWrite <= 1'b0;
	endtask

	task automatic regRd(input logic [7:0] a);
		@(posedge clock);
		regAddr <= a;
		regRead <= 1'b1;
		@(posedge clock);
		regRead <= 1'b0;
		#1 rd = regRdata;
	endtask

	function automatic dism_pkg::dism_relay_t relayExp();
		return {blk, indicators[9:4], supEn & ~|commCounterOff,
			indicators[3:0]};
	endfunction

	task automatic pulseIn(input int inp);
		@(posedge clock);
		fire[inp] <= 1'b1;
		@(posedge clock);
		fire[inp] <= 1'b0;
		repeat (40) @(posedge clock);
	endtask

	// ************
	// scenarios
	// ************
	task automatic keys();
		int was [3];
		int inp [3] = '{0, 1, 3};
		for (int k = 0; k < 3; k++)
		begin
			was = hits;
			pulseIn(inp[k]);
			check(32'(hits[k] - was[k]), {31'h0, supEn});
			check(32'(hits[0] + hits[1] + hits[2] - was[0] - was[1] - was[2]),
				{31'h0, supEn});
		end
	endtask

	task automatic sefToggle();
		for (int n = 0; n < 2; n++)
		begin
			pulseIn(4);
			blk = blk ^ supEn;
			check(32'(relayOut[11]), {31'h0, blk});
			regRd(8'h04);
			check(32'(rd[5]), {31'h0, blk});
		end
	endtask

	task automatic counterOff();
		int base;
		base = hits[0] + hits[1] + hits[2];
		@(posedge clock);
		hold[2] <= 1'b1;
		repeat (40) @(posedge clock);
		check(32'(actions.counterOff), {31'h0, supEn});
		check(32'(hits[0] + hits[1] + hits[2] - base), 32'h0);
		regRd(8'h04);
		check(rd, {24'h0, controlPowerOk, supEn, blk, 5'h04});
		@(posedge clock);
		hold[2] <= 1'b0;
		repeat (40) @(posedge clock);
		check(32'(actions.counterOff), 32'h0);
	endtask

	task automatic relays();
		for (int i = 0; i < 10; i++)
		begin
			@(posedge clock);
			indicators <= 10'(1 << i);
			commCounterOff <= 3'(i);
			repeat (3) @(posedge clock);
			check(32'(relayOut), 32'(relayExp()));
			regRd(8'h08);
			check(rd, 32'(relayExp()));
		end
	endtask

	task automatic powerLoss();
		@(posedge clock);
		indicators <= 10'h3FF;
		commCounterOff <= 3'h0;
		repeat (3) @(posedge clock);
		check(32'(relayOut), 32'h7FF | {blk, 11'h000});
		controlPowerOk <= 1'b0;
		indicators <= 10'h000;
		repeat (3) @(posedge clock);
		check(32'(relayOut), 32'h7C0 | {blk, 11'h000});
		controlPowerOk <= 1'b1;
		repeat (3) @(posedge clock);
		check(32'(relayOut), 32'(relayExp()));
	endtask

	initial
	begin
		repeat (100000) @(posedge clock);
		err_count++;
		test_done();
	end

	initial
	begin
		repeat (16) @(posedge clock);
		resetn <= 1'b1;
		check(32'(relayOut), 32'h0);
		regRd(8'h00);
		check(rd, 32'h0);
		regRd(8'h0C);
		check(rd, 32'h0);
		regRd(8'h04);
		check(rd, 32'h80);
		keys();
		sefToggle();
		counterOff();
		relays();
		regWr(8'h00, 32'h1);
		supEn = 1'b1;
		relays();
		keys();
		sefToggle();
		counterOff();
		pulseIn(4);
		blk = ~blk;
		regWr(8'h00, 32'h3);
		blk = ~blk;
		repeat (3) @(posedge clock);
		check(32'(relayOut[11]), {31'h0, blk});
		powerLoss();
		test_done();
	end
endmodule

`default_nettype wire
